// file: verilog/i2cm_pkg.sv
// Constants, register map and types for the two-wire bus master.
// Assumes a byte-wide register port and one system clock.
package i2cm_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_BAUD = 4'h3;
  localparam logic [3:0] ADDR_BUF = 4'h4;
  localparam logic [3:0] ADDR_LINES = 4'h5;
  // port_control_one fields
  localparam int MODE_LSB = 0;
  localparam int EN_BIT = 5;
  localparam int WRITE_COLLISION_FLAG_BIT = 7;
  localparam logic [3:0] MODE_HW = 4'h8;
  localparam logic [3:0] MODE_FW = 4'hb;
  // port_control_two fields
  localparam int START_BIT = 0;
  localparam int RSTART_BIT = 1;
  localparam int STOP_BIT = 2;
  localparam int RCV_BIT = 3;
  localparam int ACKDT_BIT = 4;
  // port_status_register fields
  localparam int SSEEN_BIT = 0;
  localparam int PSEEN_BIT = 1;
  localparam int BUSY_BIT = 2;
  localparam int ACKRX_BIT = 3;
  localparam int EVENT_BIT = 4;
  localparam int BCOL_BIT = 5;
  // Firmware line register fields
  localparam int FW_SCL_BIT = 0;
  localparam int FW_SDA_BIT = 1;
  // Reset values and counts
  localparam logic [7:0] BAUD_RST = 8'h04;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_1 = 2'h1;
  localparam logic [1:0] PH_2 = 2'h2;

  // One bit per bus line
  typedef struct packed {
    logic scl;
    logic sda;
  } i2cm_lines_t;

  localparam i2cm_lines_t LINES_NONE = 2'h0;
  localparam i2cm_lines_t LINES_HIGH = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_START = 6'h02,
    ST_SHOLD = 6'h04,
    ST_RSTART = 6'h08,
    ST_STOP = 6'h10,
    ST_XFER = 6'h20
  } i2cm_state_t;
endpackage

// file: verilog/i2cm_top.sv
// Two-wire bus master: register port, transmit FIFO, baud generator,
// Start/Repeated Start/Stop/byte engine. Assumes open-drain pads outside.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Transmit byte FIFO
module i2cm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW-1:0] last_ptr = AW'(DEPTH - 1);

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == last_ptr) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == last_ptr) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Operation
// - master only with master mode and enable
// - hardware pulls lines low, else releases
// - start/stop seen cleared on reset, disable
// - firmware mode: only start/stop detection active
// - event flag on each completed bus step
// - buffer write during start discarded, collision flag
// - master masks detection, events on request clear
// - master makes every clock, start, stop
// - repeated start keeps bus, no release
// - write address byte ends in zero
// - eight bits out, then acknowledge sampled
// - read: receive bytes, drive acknowledge each
// - bus clock paced by baud generator
// - start request with lines high loads generator
// - lines high at expiry: SDA low, start seen
// - one more period, clear request, hold SDA
// - low lines during start: collision, abort, idle
module i2cm_top #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe
);
  // Line synchronisers and history
  i2cm_pkg::i2cm_lines_t meta_q;
  i2cm_pkg::i2cm_lines_t line_q;
  i2cm_pkg::i2cm_lines_t prev_q;

  // Software-visible state
  logic [3:0] mode_q;
  logic en_q;
  logic write_collision_flag_q;
  logic start_req_q;
  logic rstart_req_q;
  logic stop_req_q;
  logic rcv_req_q;
  logic ackdt_q;
  logic [7:0] baud_q;
  i2cm_pkg::i2cm_lines_t fw_drv_q;
  logic sseen_q;
  logic pseen_q;
  logic ackrx_q;
  logic event_q;
  logic bcol_q;
  logic [7:0] rx_q;
  logic [7:0] rdata_q;
  i2cm_pkg::i2cm_lines_t oe_q;

  // Engine state
  i2cm_pkg::i2cm_state_t state_q, state_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] sh_q, sh_d;
  logic [7:0] brg_q, brg_d;
  i2cm_pkg::i2cm_lines_t drv_q, drv_d;
  logic rxm_q, rxm_d;
  logic ev_gen, clr_start, clr_rstart, clr_stop, clr_rcv;
  logic set_sseen, set_pseen, set_bcol, set_ackrx, rx_load, pop;

  // FIFO wires
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  // Register decode
  wire wr_ctrl1 = reg_wr && reg_addr == i2cm_pkg::ADDR_CTRL1;
  wire wr_ctrl2 = reg_wr && reg_addr == i2cm_pkg::ADDR_CTRL2;
  wire wr_status = reg_wr && reg_addr == i2cm_pkg::ADDR_STATUS;
  wire wr_baud = reg_wr && reg_addr == i2cm_pkg::ADDR_BAUD;
  wire wr_buf = reg_wr && reg_addr == i2cm_pkg::ADDR_BUF;
  wire wr_lines = reg_wr && reg_addr == i2cm_pkg::ADDR_LINES;

  wire hw_mode = en_q && mode_q == i2cm_pkg::MODE_HW;
  wire fw_mode = en_q && mode_q == i2cm_pkg::MODE_FW;
  wire bus_high = line_q.scl && line_q.sda;
  wire brg_done = brg_q == 8'h00;
  wire start_det = prev_q.scl && line_q.scl && prev_q.sda && !line_q.sda;
  wire stop_det = prev_q.scl && line_q.scl && !prev_q.sda && line_q.sda;
  wire write_collision_flag_set = wr_buf && (start_req_q || !fifo_in_ready);
  wire fifo_push = wr_buf && !write_collision_flag_set;
  wire det_event = fw_mode && (start_det || stop_det);
  wire busy = state_q != i2cm_pkg::ST_IDLE;

  wire [7:0] ctrl1_rd = {write_collision_flag_q, 1'b0, en_q, 1'b0, mode_q};
  wire [7:0] ctrl2_rd = {3'h0, ackdt_q, rcv_req_q, stop_req_q, rstart_req_q, start_req_q};
  wire [7:0] status_rd = {2'h0, bcol_q, event_q, ackrx_q, busy, pseen_q, sseen_q};
  wire [7:0] rd_mux =
    (reg_addr == i2cm_pkg::ADDR_CTRL1) ? ctrl1_rd :
    (reg_addr == i2cm_pkg::ADDR_CTRL2) ? ctrl2_rd :
    (reg_addr == i2cm_pkg::ADDR_STATUS) ? status_rd :
    (reg_addr == i2cm_pkg::ADDR_BAUD) ? baud_q :
    (reg_addr == i2cm_pkg::ADDR_BUF) ? rx_q :
    (reg_addr == i2cm_pkg::ADDR_LINES) ? {6'h0, fw_drv_q.sda, fw_drv_q.scl} : 8'h00;

  // Pin drive: hardware engine, firmware lines, or released
  wire [1:0] oe_d = hw_mode ? drv_q : (fw_mode ? fw_drv_q : i2cm_pkg::LINES_NONE);

  i2cm_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(reg_wdata),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // Engine next state
  always_comb begin
    state_d = state_q;
    ph_d = ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    drv_d = drv_q;
    rxm_d = rxm_q;
    brg_d = brg_done ? brg_q : brg_q - 8'h01;
    ev_gen = 1'b0;
    clr_start = 1'b0;
    clr_rstart = 1'b0;
    clr_stop = 1'b0;
    clr_rcv = 1'b0;
    set_sseen = 1'b0;
    set_pseen = 1'b0;
    set_bcol = 1'b0;
    set_ackrx = 1'b0;
    rx_load = 1'b0;
    pop = 1'b0;
    case (state_q)
      i2cm_pkg::ST_IDLE: begin
        if (hw_mode && start_req_q) begin
          if (!line_q.scl && !line_q.sda) begin
            set_bcol = 1'b1;
            clr_start = 1'b1;
            drv_d = i2cm_pkg::LINES_NONE;
          end else if (bus_high) begin
            state_d = i2cm_pkg::ST_START;
            brg_d = baud_q;
            drv_d = i2cm_pkg::LINES_NONE;
          end
        end else if (hw_mode && rstart_req_q) begin
          state_d = i2cm_pkg::ST_RSTART;
          ph_d = i2cm_pkg::PH_0;
          brg_d = baud_q;
          drv_d = '{scl: 1'b1, sda: 1'b0};
        end else if (hw_mode && stop_req_q) begin
          state_d = i2cm_pkg::ST_STOP;
          ph_d = i2cm_pkg::PH_0;
          brg_d = baud_q;
          drv_d = i2cm_pkg::LINES_HIGH;
        end else if (hw_mode && (rcv_req_q || fifo_out_valid)) begin
          state_d = i2cm_pkg::ST_XFER;
          ph_d = i2cm_pkg::PH_0;
          bit_d = 4'h0;
          rxm_d = rcv_req_q;
          // Released data bits, then our acknowledge level
          sh_d = rcv_req_q ? {8'hff, ackdt_q} : {fifo_out_data, 1'b1};
          pop = !rcv_req_q;
          brg_d = baud_q;
          drv_d = '{scl: 1'b1, sda: ~sh_d[8]};
        end
      end
      i2cm_pkg::ST_START: begin
        if (!line_q.scl) begin
          set_bcol = 1'b1;
          clr_start = 1'b1;
          state_d = i2cm_pkg::ST_IDLE;
        end else if (brg_done) begin
          if (bus_high) begin
            drv_d = '{scl: 1'b0, sda: 1'b1};
            set_sseen = 1'b1;
            state_d = i2cm_pkg::ST_SHOLD;
            brg_d = baud_q;
          end else begin
            set_bcol = 1'b1;
            clr_start = 1'b1;
            state_d = i2cm_pkg::ST_IDLE;
          end
        end
      end
      i2cm_pkg::ST_SHOLD: begin
        if (brg_done) begin
          clr_start = 1'b1;
          ev_gen = 1'b1;
          state_d = i2cm_pkg::ST_IDLE;
        end
      end
      i2cm_pkg::ST_RSTART: begin
        // Bus stays owned: SCL low, release SDA, raise SCL, pull SDA
        if (brg_done) begin
          brg_d = baud_q;
          if (ph_q == i2cm_pkg::PH_0) begin
            drv_d.scl = 1'b0;
            ph_d = i2cm_pkg::PH_1;
          end else if (ph_q == i2cm_pkg::PH_1) begin
            drv_d.sda = 1'b1;
            set_sseen = 1'b1;
            ph_d = i2cm_pkg::PH_2;
          end else begin
            clr_rstart = 1'b1;
            ev_gen = 1'b1;
            state_d = i2cm_pkg::ST_IDLE;
          end
        end
      end
      i2cm_pkg::ST_STOP: begin
        if (brg_done) begin
          brg_d = baud_q;
          if (ph_q == i2cm_pkg::PH_0) begin
            drv_d.scl = 1'b0;
            ph_d = i2cm_pkg::PH_1;
          end else if (ph_q == i2cm_pkg::PH_1) begin
            drv_d.sda = 1'b0;
            set_pseen = 1'b1;
            ph_d = i2cm_pkg::PH_2;
          end else begin
            clr_stop = 1'b1;
            ev_gen = 1'b1;
            state_d = i2cm_pkg::ST_IDLE;
          end
        end
      end
      i2cm_pkg::ST_XFER: begin
        if (brg_done) begin
          brg_d = baud_q;
          if (ph_q == i2cm_pkg::PH_0) begin
            drv_d.scl = 1'b0;
            ph_d = i2cm_pkg::PH_1;
          end else begin
            // Sample SDA at the end of the high half
            sh_d = {sh_q[7:0], line_q.sda};
            ph_d = i2cm_pkg::PH_0;
            if (bit_q == i2cm_pkg::LAST_BIT) begin
              drv_d = '{scl: 1'b1, sda: 1'b0};
              ev_gen = 1'b1;
              rx_load = rxm_q;
              clr_rcv = rxm_q;
              set_ackrx = !rxm_q;
              state_d = i2cm_pkg::ST_IDLE;
            end else begin
              bit_d = bit_q + 4'h1;
              drv_d = '{scl: 1'b1, sda: ~sh_d[8]};
            end
          end
        end
      end
      default: begin
        state_d = i2cm_pkg::ST_IDLE;
      end
    endcase
    if (!hw_mode) begin
      state_d = i2cm_pkg::ST_IDLE;
      drv_d = i2cm_pkg::LINES_NONE;
    end
  end

  // Synchronisers and engine registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= i2cm_pkg::LINES_HIGH;
      line_q <= i2cm_pkg::LINES_HIGH;
      prev_q <= i2cm_pkg::LINES_HIGH;
      state_q <= i2cm_pkg::ST_IDLE;
      ph_q <= i2cm_pkg::PH_0;
      bit_q <= 4'h0;
      sh_q <= 9'h1ff;
      brg_q <= 8'h00;
      drv_q <= i2cm_pkg::LINES_NONE;
      rxm_q <= 1'b0;
    end else begin
      meta_q <= '{scl: scl_in, sda: sda_in};
      line_q <= meta_q;
      prev_q <= line_q;
      state_q <= state_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      brg_q <= brg_d;
      drv_q <= drv_d;
      rxm_q <= rxm_d;
    end
  end

  // Control registers; hardware clears requests when each step is done
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= i2cm_pkg::MODE_RST;
      en_q <= 1'b0;
      baud_q <= i2cm_pkg::BAUD_RST;
      fw_drv_q <= i2cm_pkg::LINES_NONE;
      start_req_q <= 1'b0;
      rstart_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      rcv_req_q <= 1'b0;
      ackdt_q <= 1'b0;
    end else begin
      if (wr_ctrl1) begin
        mode_q <= reg_wdata[i2cm_pkg::MODE_LSB +: 4];
        en_q <= reg_wdata[i2cm_pkg::EN_BIT];
      end
      if (wr_baud) begin
        baud_q <= reg_wdata;
      end
      if (wr_lines) begin
        fw_drv_q <= '{scl: reg_wdata[i2cm_pkg::FW_SCL_BIT], sda: reg_wdata[i2cm_pkg::FW_SDA_BIT]};
      end
      if (!en_q) begin
        start_req_q <= 1'b0;
        rstart_req_q <= 1'b0;
        stop_req_q <= 1'b0;
        rcv_req_q <= 1'b0;
      end else if (wr_ctrl2) begin
        start_req_q <= reg_wdata[i2cm_pkg::START_BIT];
        rstart_req_q <= reg_wdata[i2cm_pkg::RSTART_BIT];
        stop_req_q <= reg_wdata[i2cm_pkg::STOP_BIT];
        rcv_req_q <= reg_wdata[i2cm_pkg::RCV_BIT];
        ackdt_q <= reg_wdata[i2cm_pkg::ACKDT_BIT];
      end else begin
        start_req_q <= start_req_q && !clr_start;
        rstart_req_q <= rstart_req_q && !clr_rstart;
        stop_req_q <= stop_req_q && !clr_stop;
        rcv_req_q <= rcv_req_q && !clr_rcv;
      end
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins, except against the clear by reset or disable
  always_ff @(posedge clk_sys) begin
    if (reset || !en_q) begin
      sseen_q <= 1'b0;
      pseen_q <= 1'b0;
    end else begin
      sseen_q <= set_sseen || start_det || (sseen_q && !(set_pseen || stop_det));
      pseen_q <= set_pseen || stop_det || (pseen_q && !(set_sseen || start_det));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      event_q <= 1'b0;
      bcol_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ackrx_q <= 1'b0;
      rx_q <= 8'h00;
    end else begin
      event_q <= ev_gen || det_event ||
        (event_q && !(wr_status && reg_wdata[i2cm_pkg::EVENT_BIT]));
      bcol_q <= set_bcol || (bcol_q && !(wr_status && reg_wdata[i2cm_pkg::BCOL_BIT]));
      write_collision_flag_q <= write_collision_flag_set || (write_collision_flag_q && !(wr_ctrl1 && !reg_wdata[i2cm_pkg::WRITE_COLLISION_FLAG_BIT]));
      if (set_ackrx) begin
        ackrx_q <= sh_d[0];
      end
      if (rx_load) begin
        rx_q <= sh_d[8:1];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_q <= 8'h00;
      oe_q <= i2cm_pkg::LINES_NONE;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      oe_q <= oe_d;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  assign reg_rdata = rdata_q;
  assign scl_oe = oe_q.scl;
  assign sda_oe = oe_q.sda;
endmodule

`default_nettype wire

// file: testbench/i2cm_props.sv
// Port checker for the two-wire master: register port and pin timing.
// Bound to i2cm_top by the bench top; shadows baud and control writes.
`timescale 1ns/1ns
`default_nettype none
module i2cm_props #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic [7:0] baud_q;
  logic [7:0] ctl1_q;
  logic [9:0] cnt_q;
  logic arm_q;
  logic [1:0] fwl_q;
  wire logic wr1 = reg_wr && reg_addr == i2cm_pkg::ADDR_CTRL1;
  wire logic wr2 = reg_wr && reg_addr == i2cm_pkg::ADDR_CTRL2;
  wire logic hw_on = ctl1_q[5] && ctl1_q[3:0] == i2cm_pkg::MODE_HW;
  wire logic fw_on = ctl1_q[5] && ctl1_q[3:0] == i2cm_pkg::MODE_FW;
  wire logic [9:0] bd = {2'h0, baud_q};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Cycles since the last port_control_two write of any kind
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      baud_q <= i2cm_pkg::BAUD_RST;
      ctl1_q <= 8'h00;
      arm_q <= 1'h0;
      cnt_q <= 10'h000;
      fwl_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == i2cm_pkg::ADDR_LINES) fwl_q <= reg_wdata[1:0];
      if (reg_wr && reg_addr == i2cm_pkg::ADDR_BAUD) baud_q <= reg_wdata;
      if (wr1) ctl1_q <= reg_wdata;
      if (wr2) arm_q <= reg_wdata[0] && hw_on;
      else if (sda_oe) arm_q <= 1'h0;
      cnt_q <= wr2 ? 10'h000 : cnt_q + 10'h001;
    end
  end

  property fw_follow_p;
    reg_wr && reg_addr == i2cm_pkg::ADDR_LINES && fw_on |->
      ##2 ({sda_oe, scl_oe} == fwl_q);
  endproperty

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  outs_low_a: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  rst_release_a: assert property ($fell(reset) |-> !scl_oe && !sda_oe)
    else $error("pins driven after reset");
  disable_idle_a: assert property (
    wr1 && !reg_wdata[i2cm_pkg::EN_BIT] |-> ##3 (!scl_oe && !sda_oe))
    else $error("pins driven after disable");
  start_delay_a: assert property (
    arm_q && hw_on && $rose(sda_oe) |-> !scl_oe && cnt_q > bd && cnt_q < bd + 10'h006)
    else $error("start edge outside baud window");
  start_hold_a: assert property ($rose(sda_oe) && !scl_oe |-> sda_oe [*4])
    else $error("start not held one period");
  scl_pulse_a: assert property ($rose(scl_oe) |-> scl_oe [*4])
    else $error("clock low half too short");
  scl_gap_a: assert property ($fell(scl_oe) |-> !scl_oe [*4])
    else $error("clock high half too short");
  fw_lines_a: assert property (fw_follow_p)
    else $error("firmware lines not followed");

  start_c: cover property ($rose(sda_oe) && !scl_oe);
  rx_read_c: cover property (reg_rd && reg_addr == i2cm_pkg::ADDR_BUF);
  fw_drive_c: cover property (fw_on && sda_oe);
endmodule
`default_nettype wire

// file: testbench/i2cm_slave.sv
// Behavioural two-wire slave: acks bytes, serves rd_byte on each read byte until the master nacks.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/1ns
`default_nettype none
module i2cm_slave (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  // Behaviour
  input wire logic nack,
  input wire logic [7:0] rd_byte,
  // Pull and capture
  output logic sda_pull,
  output logic [7:0] last_byte,
  output logic last_ack
);
  logic [3:0] bit_n = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic addr_ph = 1'h0;
  logic rd_mode = 1'h0;
  initial begin
    sda_pull = 1'h0;
    last_byte = 8'h00;
    last_ack = 1'h0;
  end
  // Start or stop restarts the frame; settle first so a data change
  // beside a clock fall is not taken for one
  always @(sda) begin
    #1;
    if (scl) begin
      bit_n = 4'h0;
      addr_ph = !sda;
      rd_mode = 1'h0;
      sda_pull = 1'h0;
    end
  end
  always @(posedge scl) begin
    if (bit_n < 4'h8) sh = {sh[6:0], sda};
    else last_ack = sda;
    if (bit_n == 4'h8 && sda) rd_mode = 1'h0;
    bit_n = bit_n + 4'h1;
  end
  always @(negedge scl) begin
    if (bit_n == 4'h8) begin
      last_byte = sh;
      if (addr_ph) rd_mode = sh[0];
      sda_pull = (addr_ph || !rd_mode) && !nack;
      addr_ph = 1'h0;
    end else if (bit_n == 4'h9) begin
      bit_n = 4'h0;
      tx = rd_byte;
      sda_pull = rd_mode && !tx[7];
    end else if (rd_mode) sda_pull = !tx[3'h7 - bit_n[2:0]];
  end
endmodule
`default_nettype wire

// file: testbench/i2cm_top_tb_top.sv
// Bench for the two-wire master: register tasks, slave model, random data.
// Assumes the design package is compiled first; pull-ups are modelled here.
`timescale 1ns/1ns
`default_nettype none
module i2cm_top_tb_top;
  logic clk_sys, reset, reg_wr, reg_rd, nack, scl_low, sda_low;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_byte, last_byte, st, q[10];
  logic scl_out, scl_oe, sda_out, sda_oe, sda_pull, last_ack;
  logic [7:0] fw_seq[4] = '{8'h02, 8'h03, 8'h02, 8'h00};
  logic [31:0] seed;
  int n_errors, checks;
  wire logic scl = !(scl_oe || scl_low);
  wire logic sda = !(sda_oe || sda_pull || sda_low);

  i2cm_top #(.FIFO_DEPTH(8)) i_i2cm_top (.clk_sys, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .scl_in(scl), .sda_in(sda), .scl_out, .scl_oe,
    .sda_out, .sda_oe);
  i2cm_slave i_i2cm_slave (.scl, .sda, .nack, .rd_byte, .sda_pull, .last_byte,
    .last_ack);

  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic rw);
    return {a, rw};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a, st);
    cmp8(st & m, e);
  endtask
  // Poll the event flag, then clear it
  task automatic wait_evt;
    int i;
    st = 8'h00;
    for (i = 0; i < 400 && st[i2cm_pkg::EVENT_BIT] !== 1'h1; i++) begin
      rd(i2cm_pkg::ADDR_STATUS, st);
    end
    cmp8({7'h00, st[i2cm_pkg::EVENT_BIT]}, 8'h01);
    wr(i2cm_pkg::ADDR_STATUS, 8'h10);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d, compares %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_of_test;
  end

  initial begin
    {reset, reg_wr, reg_rd, nack, scl_low, sda_low} = 6'h20;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    rd_byte = 8'h00;
    seed = 32'he314;
    n_errors = 0;
    checks = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    cmp_rd(i2cm_pkg::ADDR_CTRL1, 8'hff, 8'h00);
    cmp_rd(i2cm_pkg::ADDR_STATUS, 8'h33, 8'h00);
    cmp_rd(i2cm_pkg::ADDR_BAUD, 8'hff, i2cm_pkg::BAUD_RST);
    cmp_rd(4'hf, 8'hff, 8'h00);
    wr(i2cm_pkg::ADDR_CTRL2, 8'h01);
    cmp_rd(i2cm_pkg::ADDR_CTRL2, 8'hff, 8'h00);
    seed = lfsr(seed);
    wr(i2cm_pkg::ADDR_BAUD, 8'h03 + {5'h00, seed[2:0]});
    wr(i2cm_pkg::ADDR_CTRL1, 8'h28);
    wr(i2cm_pkg::ADDR_CTRL2, 8'h01);
    wr(i2cm_pkg::ADDR_BUF, 8'h55);
    cmp_rd(i2cm_pkg::ADDR_CTRL1, 8'hff, 8'ha8);
    wr(i2cm_pkg::ADDR_CTRL1, 8'h28);
    wait_evt;
    cmp8(st & 8'h01, 8'h01);
    cmp_rd(i2cm_pkg::ADDR_CTRL2, 8'h01, 8'h00);
    cmp8({6'h00, scl, sda}, 8'h02);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      q[i] = i == 1 ? 8'h00 : i == 2 ? 8'hff : seed[7:0];
    end
    q[0] = addr_byte(seed[14:8], 1'h0);
    foreach (q[i]) wr(i2cm_pkg::ADDR_BUF, q[i]);
    cmp_rd(i2cm_pkg::ADDR_CTRL1, 8'h80, 8'h80);
    for (int i = 0; i < 9; i++) begin
      wait_evt;
      cmp8(last_byte, q[i]);
      cmp8(st & 8'h08, 8'h00);
    end
    wr(i2cm_pkg::ADDR_CTRL1, 8'h28);
    nack <= 1'h1;
    wr(i2cm_pkg::ADDR_BUF, seed[23:16]);
    wait_evt;
    cmp8(st & 8'h08, 8'h08);
    nack <= 1'h0;
    wr(i2cm_pkg::ADDR_CTRL2, 8'h02);
    wait_evt;
    cmp8({6'h00, scl, sda}, 8'h02);
    rd_byte <= seed[31:24];
    wr(i2cm_pkg::ADDR_BUF, addr_byte(q[0][7:1], 1'h1));
    wait_evt;
    cmp8(last_byte, {q[0][7:1], 1'h1});
    wr(i2cm_pkg::ADDR_CTRL2, 8'h08);
    wait_evt;
    cmp_rd(i2cm_pkg::ADDR_BUF, 8'hff, rd_byte);
    cmp8({7'h00, last_ack}, 8'h00);
    wr(i2cm_pkg::ADDR_CTRL2, 8'h18);
    wait_evt;
    cmp_rd(i2cm_pkg::ADDR_BUF, 8'hff, rd_byte);
    cmp8({7'h00, last_ack}, 8'h01);
    wr(i2cm_pkg::ADDR_CTRL2, 8'h04);
    wait_evt;
    cmp8(st & 8'h02, 8'h02);
    cmp8({6'h00, scl, sda}, 8'h03);
    cmp_rd(i2cm_pkg::ADDR_CTRL2, 8'h07, 8'h00);
    scl_low <= 1'h1;
    sda_low <= 1'h1;
    repeat (4) @(posedge clk_sys);
    wr(i2cm_pkg::ADDR_CTRL2, 8'h01);
    repeat (4) @(posedge clk_sys);
    cmp_rd(i2cm_pkg::ADDR_STATUS, 8'h20, 8'h20);
    cmp_rd(i2cm_pkg::ADDR_CTRL2, 8'h01, 8'h00);
    cmp8({6'h00, sda_oe, scl_oe}, 8'h00);
    scl_low <= 1'h0;
    sda_low <= 1'h0;
    wr(i2cm_pkg::ADDR_STATUS, 8'h30);
    cmp_rd(i2cm_pkg::ADDR_STATUS, 8'h20, 8'h00);
    wr(i2cm_pkg::ADDR_CTRL1, 8'h2b);
    wr(i2cm_pkg::ADDR_STATUS, 8'h30);
    foreach (fw_seq[i]) begin
      wr(i2cm_pkg::ADDR_LINES, fw_seq[i]);
      repeat (4) @(posedge clk_sys);
      if (i == 0) wait_evt;
      if (i == 0) cmp8(st & 8'h01, 8'h01);
    end
    wait_evt;
    cmp8(st & 8'h02, 8'h02);
    // Mid-run reset, then one firmware start before the disable check
    reset <= 1'h1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    cmp_rd(i2cm_pkg::ADDR_STATUS, 8'h33, 8'h00);
    cmp_rd(i2cm_pkg::ADDR_CTRL1, 8'hff, 8'h00);
    wr(i2cm_pkg::ADDR_CTRL1, 8'h2b);
    wr(i2cm_pkg::ADDR_LINES, 8'h02);
    wait_evt;
    cmp8(st & 8'h01, 8'h01);
    wr(i2cm_pkg::ADDR_CTRL1, 8'h00);
    cmp_rd(i2cm_pkg::ADDR_STATUS, 8'h03, 8'h00);
    end_of_test;
  end
endmodule

bind i2cm_top i2cm_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_i2cm_props (.clk_sys, .reset,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_in, .sda_in, .scl_out,
  .scl_oe, .sda_out, .sda_oe);
`default_nettype wire
